// ==== shared/ssi_pkg.sv ====
// Constants for the power-down and subtract instruction executor
package ssi_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_INSTR = 8'h00;
  localparam logic [7:0] ADDR_ACC = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_WATCHDOG = 8'h0c;
  localparam logic [7:0] ADDR_FSEL = 8'h10;
  localparam logic [7:0] ADDR_FDATA = 8'h14;
  localparam logic [7:0] ADDR_WAKE = 8'h18;
  // ----------------------------------------------------------------
  // Status field positions and reset values
  // ----------------------------------------------------------------
  localparam int C_BIT = 0;
  localparam int HALF_CARRY_BIT = 1;
  localparam int Z_BIT = 2;
  localparam int PWR_DOWN_BIT = 3;
  localparam int TIMEOUT_BIT = 4;
  localparam logic [7:0] STATUS_RST = 8'h18;
  localparam logic [7:0] STATUS_SW_MASK = 8'h07;
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [6:0] FSEL_RST = 7'h00;
  localparam logic [7:0] WATCHDOG_CLEAR = 8'h00;
  // ----------------------------------------------------------------
  // Opcode decoding
  // ----------------------------------------------------------------
  localparam logic [13:0] OP_SLEEP = 14'h0063;
  localparam logic [4:0] OP_LIT_SUB_HI = 5'h1e;
  localparam logic [5:0] OP_REG_SUB_HI = 6'h02;
  localparam int OP_DEST_BIT = 7;
  // ----------------------------------------------------------------
  // Bus encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage : ssi_pkg

// ==== hw/ssi_core.sv ====
// Executor for the power-down, literal-subtract and register-subtract instructions
//
// Behaviour
// - Power-down clears the watchdog counter and its prescaler to zero.
// - Power-down clears power_down_flag_n, sets timeout_flag_n and leaves other status bits.
// - Opcode 00 0000 0110 0011 is power-down, one cycle, then the oscillator halts.
// - Opcode 11 110x kkkk kkkk writes literal minus accumulator into the accumulator.
// - Register subtract computes file register minus accumulator in one cycle.
// - Destination bit 0 sends the difference to the accumulator, 1 to the file register.
// - After a subtract the carry is 1 when the difference is zero or positive.
// - After a subtract the carry is 0 on a borrow and the result wraps to 8 bits.
`timescale 1ns/10ps
`default_nettype none

module ssi_core #(
  parameter int PRE_W = 8,
  parameter int WDOG_W = 8,
  parameter int FILE_DEPTH = 128
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic osc_halted
);
  // ----------------------------------------------------------------
  // Arithmetic
  // ----------------------------------------------------------------
  // Returns {half_carry, carry, difference}; carries are inverted borrows
  function automatic logic [9:0] ssi_sub(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] full;
    logic [4:0] low;
    full = {1'b0, a} - {1'b0, b};
    low = {1'b0, a[3:0]} - {1'b0, b[3:0]};
    return {~low[4], ~full[8], full[7:0]};
  endfunction : ssi_sub

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] file_mem [FILE_DEPTH];
  logic [7:0] acc_reg, acc_next;
  logic [7:0] status_reg, status_next;
  logic [PRE_W-1:0] pre_reg, pre_next;
  logic [WDOG_W-1:0] wdog_reg, wdog_next;
  logic [6:0] fsel_reg, fsel_next;
  logic sleep_reg, sleep_next;
  logic wr_reg, wr_next;
  logic [7:0] addr_reg, addr_next;
  logic [31:0] rdata_reg, rdata_next;
  logic mem_we;
  logic [6:0] mem_addr;
  logic [7:0] mem_wdata;

  logic addr_phase;
  logic [13:0] op;
  logic [7:0] op_lit;
  logic [6:0] op_faddr;
  logic [7:0] fval;
  logic [7:0] sub_a;
  logic exec_ok, exec_sleep, exec_lit_sub, exec_reg_sub, exec_sub, sw_wr;
  logic [9:0] sub_res;

  assign addr_phase = hsel && htrans[1] && hready;
  assign op = hwdata[13:0];
  assign op_lit = hwdata[7:0];
  assign op_faddr = hwdata[6:0];
  assign fval = file_mem[op_faddr];
  // Instructions are refused while the oscillator is halted
  assign exec_ok = wr_reg && addr_reg == ssi_pkg::ADDR_INSTR && !sleep_reg;
  assign exec_sleep = exec_ok && op == ssi_pkg::OP_SLEEP;
  assign exec_lit_sub = exec_ok && op[13:9] == ssi_pkg::OP_LIT_SUB_HI;
  assign exec_reg_sub = exec_ok && op[13:8] == ssi_pkg::OP_REG_SUB_HI;
  assign exec_sub = exec_lit_sub || exec_reg_sub;
  assign sub_a = exec_lit_sub ? op_lit : fval;
  assign sub_res = ssi_sub(sub_a, acc_reg);
  assign sw_wr = wr_reg && !exec_ok;

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  always_comb
  begin
    wr_next = 1'b0;
    addr_next = addr_reg;
    rdata_next = 32'h0000_0000;
    if (addr_phase)
    begin
      // Only whole-word writes are acted upon
      wr_next = hwrite && hsize == ssi_pkg::HSIZE_WORD;
      addr_next = haddr[7:0];
      if (!hwrite)
      begin
        case (haddr[7:0])
          ssi_pkg::ADDR_ACC: rdata_next = {24'h000000, acc_reg};
          ssi_pkg::ADDR_STATUS: rdata_next = {24'h000000, status_reg};
          ssi_pkg::ADDR_WATCHDOG: rdata_next = 32'({pre_reg, wdog_reg});
          ssi_pkg::ADDR_FSEL: rdata_next = {25'h0000000, fsel_reg};
          ssi_pkg::ADDR_FDATA: rdata_next = {24'h000000, file_mem[fsel_reg]};
          ssi_pkg::ADDR_WAKE: rdata_next = {31'h00000000, sleep_reg};
          default: rdata_next = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr_reg <= 1'b0;
      addr_reg <= 8'h00;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      wr_reg <= wr_next;
      addr_reg <= addr_next;
      rdata_reg <= rdata_next;
    end
  end

  assign hrdata = rdata_reg;
  // Zero-wait slave: ready and OKAY are constant flip-flops
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Execution
  // ----------------------------------------------------------------
  always_comb
  begin
    acc_next = acc_reg;
    status_next = status_reg;
    fsel_next = fsel_reg;
    sleep_next = sleep_reg;
    mem_we = 1'b0;
    mem_addr = fsel_reg;
    mem_wdata = hwdata[7:0];
    if (exec_sleep)
    begin
      status_next[ssi_pkg::PWR_DOWN_BIT] = 1'b0;
      status_next[ssi_pkg::TIMEOUT_BIT] = 1'b1;
      sleep_next = 1'b1;
    end
    else if (exec_sub)
    begin
      status_next[ssi_pkg::C_BIT] = sub_res[8];
      status_next[ssi_pkg::HALF_CARRY_BIT] = sub_res[9];
      status_next[ssi_pkg::Z_BIT] = sub_res[7:0] == 8'h00;
      if (exec_reg_sub && op[ssi_pkg::OP_DEST_BIT])
      begin
        mem_we = 1'b1;
        mem_addr = op_faddr;
        mem_wdata = sub_res[7:0];
      end
      else
        acc_next = sub_res[7:0];
    end
    else if (sw_wr)
    begin
      case (addr_reg)
        ssi_pkg::ADDR_ACC: acc_next = hwdata[7:0];
        ssi_pkg::ADDR_STATUS:
          status_next = (status_reg & ~ssi_pkg::STATUS_SW_MASK)
                        | (hwdata[7:0] & ssi_pkg::STATUS_SW_MASK);
        ssi_pkg::ADDR_FSEL: fsel_next = hwdata[6:0];
        ssi_pkg::ADDR_FDATA: mem_we = 1'b1;
        ssi_pkg::ADDR_WAKE: sleep_next = 1'b0;
        default: acc_next = acc_reg;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      acc_reg <= ssi_pkg::ACC_RST;
      status_reg <= ssi_pkg::STATUS_RST;
      fsel_reg <= ssi_pkg::FSEL_RST;
      sleep_reg <= 1'b0;
    end
    else
    begin
      acc_reg <= acc_next;
      status_reg <= status_next;
      fsel_reg <= fsel_next;
      sleep_reg <= sleep_next;
    end
  end

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  always_comb
  begin
    pre_next = pre_reg;
    wdog_next = wdog_reg;
    // Watchdog runs on the core clock only while awake
    if (!sleep_reg)
    begin
      pre_next = pre_reg + 1'b1;
      if (&pre_reg)
        wdog_next = wdog_reg + 1'b1;
    end
    // Clearing wins over counting in the power-down cycle
    if (exec_sleep)
    begin
      wdog_next = WDOG_W'(ssi_pkg::WATCHDOG_CLEAR);
      pre_next = '0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pre_reg <= '0;
      wdog_reg <= WDOG_W'(ssi_pkg::WATCHDOG_CLEAR);
    end
    else
    begin
      pre_reg <= pre_next;
      wdog_reg <= wdog_next;
    end
  end

  // Array has no reset; contents are undefined until written
  always_ff @(posedge core_clk)
  begin
    if (mem_we)
      file_mem[mem_addr] <= mem_wdata;
  end

  assign osc_halted = sleep_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  a_sleep_wdog_clear: assert property (exec_sleep |=> wdog_reg == '0 && pre_reg == '0)
    else $error("Watchdog not cleared by power-down");
  a_sleep_flag_set: assert property (exec_sleep |=> !status_reg[3] && status_reg[4])
    else $error("Power-down flags wrong");
  a_sleep_flags_kept: assert property (exec_sleep |=> status_reg[2:0] == $past(status_reg[2:0]))
    else $error("Power-down changed other status bits");
  a_sleep_halts_osc: assert property (exec_sleep |=> osc_halted [*2])
    else $error("Oscillator not halted after power-down");
  a_literal_sub_acc: assert property (exec_lit_sub |=> acc_reg == 8'($past(op_lit) - $past(acc_reg)))
    else $error("Literal subtract result wrong");
  a_reg_sub_acc: assert property (exec_reg_sub && !op[7] |=> acc_reg == 8'($past(fval) - $past(acc_reg)))
    else $error("Register subtract to accumulator wrong");
  a_reg_sub_file: assert property (exec_reg_sub && op[7] |=>
      file_mem[$past(op_faddr)] == 8'($past(fval) - $past(acc_reg)) && $stable(acc_reg))
    else $error("Register subtract to file wrong");
  a_carry_no_borrow: assert property (exec_sub && sub_a >= acc_reg |=> status_reg[0])
    else $error("Carry clear without borrow");
  a_carry_borrow: assert property (exec_sub && sub_a < acc_reg |=> !status_reg[0])
    else $error("Carry set on borrow");
  a_zero_half_flag: assert property (exec_sub |=> status_reg[2] == ($past(sub_a) == $past(acc_reg))
      && status_reg[1] == ($past(sub_a[3:0]) >= $past(acc_reg[3:0])))
    else $error("Zero or half carry flag wrong");

  // A halted core must ignore opcodes and keep its watchdog still
  a_halt_refuses_instr: assert property (wr_reg && addr_reg == ssi_pkg::ADDR_INSTR && sleep_reg
      |=> $stable(acc_reg) && $stable(status_reg))
    else $error("Opcode acted on while halted");
  a_halt_freezes_wdog: assert property (sleep_reg |=> $stable(wdog_reg) && $stable(pre_reg))
    else $error("Watchdog moved while halted");
  a_wake_clears_halt: assert property (sw_wr && addr_reg == ssi_pkg::ADDR_WAKE |=> !osc_halted)
    else $error("Wake write did not restart oscillator");
  // Power flags belong to hardware only
  a_status_sw_flags: assert property (sw_wr && addr_reg == ssi_pkg::ADDR_STATUS
      |=> $stable(status_reg[ssi_pkg::TIMEOUT_BIT]) && $stable(status_reg[ssi_pkg::PWR_DOWN_BIT]))
    else $error("Software write changed power flags");

  // Main scenarios
  c_sleep: cover property (exec_sleep ##1 osc_halted);
  c_literal_borrow: cover property (exec_lit_sub && op_lit < acc_reg);
  c_reg_to_file: cover property (exec_reg_sub && op[7]);
  c_zero_result: cover property (exec_sub && sub_res[7:0] == 8'h00);
  c_wake: cover property (osc_halted ##1 !osc_halted);
endmodule : ssi_core

`default_nettype wire

// ==== test/ssi_core_tb.sv ====
// Self-checking bench for the power-down and subtract executor
`timescale 1ns/10ps
`default_nettype none

module ssi_core_tb;
  logic core_clk;
  logic resetn;
  logic hsel;
  logic hwrite;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout;
  logic hresp;
  logic osc_halted;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;
  integer seed = 32'h328f;
  int acc_m = 0;
  int st_m = 8'h18;
  int file_m [128];
  logic [31:0] rd;

  ssi_core i_dut (
    .core_clk(core_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .osc_halted(osc_halted)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // A hung handshake ends the run here rather than stalling forever
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fail_count++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    // Ready and read data are looked at mid-cycle, where they are settled
    @(negedge core_clk);
    while (hreadyout !== 1'b1)
      @(negedge core_clk);
    @(posedge core_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(negedge core_clk);
    while (hreadyout !== 1'b1)
      @(negedge core_clk);
    rd = hrdata;
    @(posedge core_clk);
  endtask : bus

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask : rchk

  // Random subtract; a quarter of the cases force equal operands for a zero result
  task automatic sub_step();
    int a, m, f, d, r, op;
    logic lit;
    a = $random(seed) & 255;
    m = $random(seed) & 255;
    if (($random(seed) & 3) == 0)
      m = a;
    lit = $random(seed) & 1;
    f = $random(seed) & 127;
    d = $random(seed) & 1;
    bus(1'b1, ssi_pkg::ADDR_ACC, a);
    if (lit)
      op = 14'h3c00 | (($random(seed) & 1) << 8) | m;
    else
    begin
      bus(1'b1, ssi_pkg::ADDR_FSEL, f);
      bus(1'b1, ssi_pkg::ADDR_FDATA, m);
      file_m[f] = m;
      op = 14'h0200 | (d << 7) | f;
    end
    bus(1'b1, ssi_pkg::ADDR_INSTR, op);
    r = (m - a) & 255;
    st_m = (st_m & 8'h18) | (r == 0 ? 4 : 0) | ((m & 15) >= (a & 15) ? 2 : 0) | (m >= a ? 1 : 0);
    acc_m = (lit || d == 0) ? r : a;
    if (!lit && d == 1)
      file_m[f] = r;
    rchk("acc", ssi_pkg::ADDR_ACC, acc_m);
    rchk("status", ssi_pkg::ADDR_STATUS, st_m);
    if (!lit)
      rchk("file", ssi_pkg::ADDR_FDATA, file_m[f]);
  endtask : sub_step

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    resetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = ssi_pkg::HSIZE_WORD;
    hwdata = 32'h0;
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    rchk("status", ssi_pkg::ADDR_STATUS, 32'h18);
    rchk("acc", ssi_pkg::ADDR_ACC, 32'h0);
    bus(1'b1, 8'h1c, 32'hffffffff);
    rchk("unmapped", 8'h1c, 32'h0);
    // Software may touch only the arithmetic flags
    bus(1'b1, ssi_pkg::ADDR_STATUS, 32'hff);
    st_m = 8'h1f;
    rchk("status", ssi_pkg::ADDR_STATUS, st_m);
    // Byte-sized writes are ignored
    hsize <= 3'h0;
    bus(1'b1, ssi_pkg::ADDR_ACC, 32'h5a);
    hsize <= ssi_pkg::HSIZE_WORD;
    rchk("acc", ssi_pkg::ADDR_ACC, 32'h0);
    $display("test reset done");
    repeat (24) sub_step();
    $display("test subtract done");
    // The clear is only worth checking once the watchdog has counted
    bus(1'b0, ssi_pkg::ADDR_WATCHDOG, 32'h0);
    chk("watchdog running", 32'h1, {31'h0, rd != 32'h0});
    bus(1'b1, ssi_pkg::ADDR_INSTR, 32'h0063);
    st_m = (st_m & 8'h07) | 8'h10;
    rchk("status", ssi_pkg::ADDR_STATUS, st_m);
    rchk("watchdog", ssi_pkg::ADDR_WATCHDOG, 32'h0);
    chk("osc_halted", 32'h1, {31'h0, osc_halted});
    // Opcodes arriving while halted must leave everything alone
    bus(1'b1, ssi_pkg::ADDR_INSTR, 32'h3c05);
    rchk("acc", ssi_pkg::ADDR_ACC, acc_m);
    rchk("watchdog", ssi_pkg::ADDR_WATCHDOG, 32'h0);
    bus(1'b1, ssi_pkg::ADDR_WAKE, 32'h0);
    rchk("wake", ssi_pkg::ADDR_WAKE, 32'h0);
    chk("osc_halted", 32'h0, {31'h0, osc_halted});
    $display("test power down done");
    repeat (12) sub_step();
    $display("test subtract after wake done");
    final_report();
  end
endmodule : ssi_core_tb

`default_nettype wire
